// [byte_cpu_cfg.svh]
`ifndef BYTE_CPU_CFG_SVH
`define BYTE_CPU_CFG_SVH
`define ACC_RST 8'h00
`define B_RST 8'h00
`define SP_RST 8'h07
`define DATA_POINTER_RST 16'h0000
`define PAGE_LSB 11
`define XRAM_AW 10
`endif

// [byte_cpu_instruction_decode.sv]
`timescale 1ns/100ps
`default_nettype none
`include "byte_cpu_cfg.svh"
module byte_cpu_instruction_decode #(
	parameter int XRAM_AW = `XRAM_AW
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// instruction from fetch
	input wire logic ins_valid,
	input wire byte_cpu_pkg::instr_t ins,
	// operand read, answered in the same cycle
	output var byte_cpu_pkg::mem_req_t rd,
	input wire logic [7:0] rd_data,
	// write and step result
	output var byte_cpu_pkg::mem_wr_t wr,
	output var byte_cpu_pkg::step_t step,
	output var logic done,
	// core state
	output var logic [7:0] acc,
	output var logic [7:0] b,
	output var logic cy,
	output var logic ac,
	output var logic ov,
	output var logic [15:0] data_pointer,
	output var logic [7:0] sp
);
	import byte_cpu_pkg::*;

	function automatic logic [1:0] op_len(input logic [7:0] o);
		logic [3:0] h;
		h = o[7:4];
		op_len = 2'h1;
		case (o[3:0])
			4'h0: if (h inside {4'h1, 4'h2, 4'h3, 4'h9}) op_len = 2'h3;
				else if (h != 4'h0 && h < 4'he) op_len = 2'h2;
			4'h1: op_len = 2'h2;
			4'h2: if (h < 4'h2) op_len = 2'h3;
				else if (h > 4'h3 && h < 4'he) op_len = 2'h2;
			4'h3: if (h inside {4'h4, 4'h5, 4'h6}) op_len = 2'h3;
			4'h4: if (h == 4'hb) op_len = 2'h3;
				else if ((h > 4'h1 && h < 4'h8) || h == 4'h9) op_len = 2'h2;
			4'h5: if (h inside {4'h7, 4'h8, 4'hb, 4'hd}) op_len = 2'h3;
				else if (h != 4'ha) op_len = 2'h2;
			4'h6, 4'h7: if (h == 4'hb) op_len = 2'h3;
				else if (h inside {4'h7, 4'h8, 4'ha}) op_len = 2'h2;
			default: if (h == 4'hb) op_len = 2'h3;
				else if (h inside {4'h7, 4'h8, 4'ha, 4'hd}) op_len = 2'h2;
		endcase
	endfunction

	function automatic mem_req_t src_of(input logic [7:0] o,
		input logic [7:0] a);
		src_of = '{SPC_NONE, 16'h0000};
		if (o[3])
			src_of = '{SPC_WREG, {13'h0000, o[2:0]}};
		else if (o[3:1] == 3'h3)
			src_of = '{SPC_PTR, {15'h0000, o[0]}};
		else if (o[3:0] == 4'h5)
			src_of = '{SPC_DIR, {8'h00, a}};
	endfunction

	// {carry, half carry, overflow, sum}
	function automatic logic [10:0] add8(input logic [7:0] a,
		input logic [7:0] x, input logic c);
		logic [4:0] l;
		logic [8:0] s;
		l = {1'b0, a[3:0]} + {1'b0, x[3:0]} + {4'h0, c};
		s = {1'b0, a} + {1'b0, x} + {8'h00, c};
		add8 = {s[8], l[4], (a[7] == x[7]) && (s[7] != a[7]), s[7:0]};
	endfunction

	function automatic logic [7:0] logic_fn(input logic [1:0] k,
		input logic [7:0] a, input logic [7:0] x);
		logic_fn = (k == 2'h0) ? (a | x) : (k == 2'h1) ? (a & x) : (a ^ x);
	endfunction

	function automatic logic [15:0] rel_tgt(input logic [15:0] p,
		input logic [7:0] d);
		rel_tgt = p + {{8{d[7]}}, d};
	endfunction

	logic [7:0] acc_r, b_r, sp_r, acc_nxt, b_nxt, sp_nxt, op, b1, b2, opv;
	logic cy_r, ac_r, ov_r, cy_nxt, ac_nxt, ov_nxt, jmp, call, unk;
	logic [15:0] data_pointer_r, data_pointer_nxt, pc_nxt, tgt, xaddr, prod;
	logic [1:0] len;
	logic [10:0] ra, rs;
	logic [8:0] t;
	mem_req_t src, dreq, breq;
	mem_wr_t wr_nxt, wr_r;
	step_t step_r;
	logic done_r;

	assign op = ins.opcode;
	assign b1 = ins.b1;
	assign b2 = ins.b2;
	assign len = op_len(op);
	assign pc_nxt = ins.pc + {14'h0000, len};
	assign xaddr = 16'(data_pointer_r[XRAM_AW-1:0]);
	assign dreq = '{SPC_DIR, {8'h00, b1}};
	assign breq = '{SPC_BIT, {8'h00, b1}};

	always_comb begin
		src = src_of(op, b1);
		opv = (op[3:0] == 4'h4) ? b1 : rd_data;
		ra = add8(acc_r, opv, cy_r & op[4]);
		rs = add8(acc_r, ~opv, ~cy_r);
		prod = acc_r * b_r;
		t = 9'h000;
		acc_nxt = acc_r;
		b_nxt = b_r;
		cy_nxt = cy_r;
		ac_nxt = ac_r;
		ov_nxt = ov_r;
		data_pointer_nxt = data_pointer_r;
		sp_nxt = sp_r;
		rd = '{SPC_NONE, 16'h0000};
		wr_nxt = '{1'b0, SPC_NONE, 16'h0000, 8'h00};
		jmp = 1'b0;
		tgt = pc_nxt;
		call = 1'b0;
		unk = 1'b0;
		casez (op)
			8'h00: unk = 1'b0;
			8'b000?_0100: acc_nxt = op[4] ? acc_r - 8'h01 : acc_r + 8'h01;
			8'b000?_0101, 8'b000?_011?, 8'b000?_1???: begin
				rd = src;
				wr_nxt = '{1'b1, src.space, src.addr,
					op[4] ? rd_data - 8'h01 : rd_data + 8'h01};
			end
			8'b001?_01??, 8'b001?_1???: begin
				rd = src;
				{cy_nxt, ac_nxt, ov_nxt, acc_nxt} = ra;
			end
			8'b1001_01??, 8'b1001_1???: begin
				rd = src;
				cy_nxt = ~rs[10];
				ac_nxt = ~rs[9];
				ov_nxt = rs[8];
				acc_nxt = rs[7:0];
			end
			8'b0100_01??, 8'b0100_1???, 8'b0101_01??, 8'b0101_1???,
			8'b0110_01??, 8'b0110_1???: begin
				rd = src;
				acc_nxt = logic_fn(op[5:4], acc_r, opv);
			end
			8'h42, 8'h52, 8'h62: begin
				rd = dreq;
				wr_nxt = '{1'b1, SPC_DIR, dreq.addr,
					logic_fn(op[5:4], rd_data, acc_r)};
			end
			8'h43, 8'h53, 8'h63: begin
				rd = dreq;
				wr_nxt = '{1'b1, SPC_DIR, dreq.addr,
					logic_fn(op[5:4], rd_data, b2)};
			end
			8'ha4: begin
				acc_nxt = prod[7:0];
				b_nxt = prod[15:8];
				cy_nxt = 1'b0;
				ov_nxt = |prod[15:8];
			end
			8'h84: begin
				cy_nxt = 1'b0;
				ov_nxt = (b_r == 8'h00);
				if (b_r != 8'h00) begin
					acc_nxt = acc_r / b_r;
					b_nxt = acc_r % b_r;
				end
			end
			8'hd4: begin
				t = {1'b0, acc_r} + ((acc_r[3:0] > 4'h9 || ac_r) ? 9'h006 : 9'h000);
				cy_nxt = cy_r | t[8];
				if (t[7:4] > 4'h9 || cy_nxt) begin
					t = {1'b0, t[7:0]} + 9'h060;
					cy_nxt = 1'b1;
				end
				acc_nxt = t[7:0];
			end
			8'he4: acc_nxt = 8'h00;
			8'hf4: acc_nxt = ~acc_r;
			8'h03: acc_nxt = {acc_r[0], acc_r[7:1]};
			8'h13: {acc_nxt, cy_nxt} = {cy_r, acc_r};
			8'h23: acc_nxt = {acc_r[6:0], acc_r[7]};
			8'h33: {cy_nxt, acc_nxt} = {acc_r, cy_r};
			8'hc4: acc_nxt = {acc_r[3:0], acc_r[7:4]};
			8'ha3: data_pointer_nxt = data_pointer_r + 16'h0001;
			8'h90: data_pointer_nxt = {b1, b2};
			8'h83, 8'h93: begin
				rd = '{SPC_CODE,
					{8'h00, acc_r} + (op[4] ? data_pointer_r : pc_nxt)};
				acc_nxt = rd_data;
			end
			8'he0: begin
				rd = '{SPC_XDATA, xaddr};
				acc_nxt = rd_data;
			end
			8'hf0: wr_nxt = '{1'b1, SPC_XDATA, xaddr, acc_r};
			8'he2, 8'he3: begin
				rd = '{SPC_XPTR, {15'h0000, op[0]}};
				acc_nxt = rd_data;
			end
			8'hf2, 8'hf3:
				wr_nxt = '{1'b1, SPC_XPTR, {15'h0000, op[0]}, acc_r};
			8'h74: acc_nxt = b1;
			8'b1110_01??, 8'b1110_1???: begin
				rd = src;
				acc_nxt = rd_data;
			end
			8'b1111_01??, 8'b1111_1???:
				wr_nxt = '{1'b1, src.space, src.addr, acc_r};
			8'h75: wr_nxt = '{1'b1, SPC_DIR, dreq.addr, b2};
			8'b0111_011?, 8'b0111_1???:
				wr_nxt = '{1'b1, src.space, src.addr, b1};
			8'h85: begin
				rd = dreq;
				wr_nxt = '{1'b1, SPC_DIR, {8'h00, b2}, rd_data};
			end
			8'b1000_011?, 8'b1000_1???: begin
				rd = src;
				wr_nxt = '{1'b1, SPC_DIR, dreq.addr, rd_data};
			end
			8'b1010_011?, 8'b1010_1???: begin
				rd = dreq;
				wr_nxt = '{1'b1, src.space, src.addr, rd_data};
			end
			8'hc0: begin
				rd = dreq;
				sp_nxt = sp_r + 8'h01;
				wr_nxt = '{1'b1, SPC_IRAM, {8'h00, sp_nxt}, rd_data};
			end
			8'hd0: begin
				rd = '{SPC_IRAM, {8'h00, sp_r}};
				sp_nxt = sp_r - 8'h01;
				wr_nxt = '{1'b1, SPC_DIR, dreq.addr, rd_data};
			end
			8'b1100_01??, 8'b1100_1???: begin
				rd = src;
				acc_nxt = rd_data;
				wr_nxt = '{1'b1, src.space, src.addr, acc_r};
			end
			8'hd6, 8'hd7: begin
				rd = src;
				acc_nxt = {acc_r[7:4], rd_data[3:0]};
				wr_nxt = '{1'b1, src.space, src.addr, {rd_data[7:4], acc_r[3:0]}};
			end
			8'hc3: cy_nxt = 1'b0;
			8'hd3: cy_nxt = 1'b1;
			8'hb3: cy_nxt = ~cy_r;
			8'hc2, 8'hd2, 8'hb2: begin
				rd = breq;
				wr_nxt = '{1'b1, SPC_BIT, breq.addr, {7'h00,
					op[7:4] == 4'hb ? ~rd_data[0] : op[4]}};
			end
			8'h82, 8'hb0: begin
				rd = breq;
				cy_nxt = cy_r & (rd_data[0] ^ op[5]);
			end
			8'h72, 8'ha0: begin
				rd = breq;
				cy_nxt = cy_r | (rd_data[0] ^ op[7]);
			end
			8'ha2: begin
				rd = breq;
				cy_nxt = rd_data[0];
			end
			8'h92: wr_nxt = '{1'b1, SPC_BIT, breq.addr, {7'h00, cy_r}};
			8'b???0_0001, 8'b???1_0001: begin
				jmp = 1'b1;
				call = op[4];
				tgt = {pc_nxt[15:`PAGE_LSB], op[7:5], b1};
			end
			8'h02, 8'h12: begin
				jmp = 1'b1;
				call = op[4];
				tgt = {b1, b2};
			end
			8'h80: begin
				jmp = 1'b1;
				tgt = rel_tgt(pc_nxt, b1);
			end
			8'h40, 8'h50, 8'h60, 8'h70: begin
				jmp = (op[5] ? (acc_r == 8'h00) : cy_r) ^ op[4];
				tgt = rel_tgt(pc_nxt, b1);
			end
			8'h10, 8'h20, 8'h30: begin
				rd = breq;
				jmp = rd_data[0] ^ (op[5:4] == 2'h3);
				tgt = rel_tgt(pc_nxt, b2);
				if (op[5:4] == 2'h1 && rd_data[0])
					wr_nxt = '{1'b1, SPC_BIT, breq.addr, 8'h00};
			end
			default: unk = 1'b1;
		endcase
		if (call)
			sp_nxt = sp_r + 8'h02;
	end

	// core state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			acc_r <= `ACC_RST;
			b_r <= `B_RST;
			cy_r <= 1'b0;
			ac_r <= 1'b0;
			ov_r <= 1'b0;
			data_pointer_r <= `DATA_POINTER_RST;
			sp_r <= `SP_RST;
		end else if (ins_valid) begin
			acc_r <= acc_nxt;
			b_r <= b_nxt;
			cy_r <= cy_nxt;
			ac_r <= ac_nxt;
			ov_r <= ov_nxt;
			data_pointer_r <= data_pointer_nxt;
			sp_r <= sp_nxt;
		end
	end

	// step result and write strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			done_r <= 1'b0;
			wr_r <= '{1'b0, SPC_NONE, 16'h0000, 8'h00};
			step_r <= '0;
		end else begin
			done_r <= ins_valid;
			wr_r.we <= ins_valid & wr_nxt.we;
			if (ins_valid) begin
				wr_r.space <= wr_nxt.space;
				wr_r.addr <= wr_nxt.addr;
				wr_r.data <= wr_nxt.data;
				step_r <= '{len, jmp, jmp ? tgt : pc_nxt, call, pc_nxt, unk};
			end
		end
	end

	assign wr = wr_r;
	assign step = step_r;
	assign done = done_r;
	assign acc = acc_r;
	assign b = b_r;
	assign cy = cy_r;
	assign ac = ac_r;
	assign ov = ov_r;
	assign data_pointer = data_pointer_r;
	assign sp = sp_r;
endmodule
`default_nettype wire

// [byte_cpu_instruction_decode_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module byte_cpu_decode_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// decode ports
	input wire logic ins_valid,
	input wire byte_cpu_pkg::instr_t ins,
	input wire byte_cpu_pkg::mem_req_t rd,
	input wire logic [7:0] rd_data,
	input wire byte_cpu_pkg::mem_wr_t wr,
	input wire byte_cpu_pkg::step_t step,
	input wire logic done,
	input wire logic [7:0] acc,
	input wire logic [7:0] b,
	input wire logic cy,
	input wire logic ac,
	input wire logic ov,
	input wire logic [15:0] data_pointer,
	input wire logic [7:0] sp
);
	import byte_cpu_pkg::*;
	logic [15:0] nxt2;
	logic [15:0] rel_tgt;
	assign nxt2 = ins.pc + 16'h0002;
	assign rel_tgt = nxt2 + {{8{ins.b1[7]}}, ins.b1};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	done_pulse_a: assert property (done == $past(ins_valid))
		else $error("done not one cycle after instruction");
	long_dest_a: assert property (ins_valid && ins.opcode == 8'h02 |=>
		step.pc_next == $past({ins.b1, ins.b2}) && step.len == 2'd3)
		else $error("long jump target wrong");
	page_dest_a: assert property (
		ins_valid && ins.opcode[4:0] == 5'h01 |=>
		step.pc_next == $past({nxt2[15:11], ins.opcode[7:5], ins.b1}))
		else $error("page jump target wrong");
	short_dest_a: assert property (ins_valid && ins.opcode == 8'h80 |=>
		step.taken && step.pc_next == $past(rel_tgt))
		else $error("short jump target wrong");
	inc_direct_a: assert property (ins_valid && ins.opcode == 8'h05 |=>
		wr.we && wr.space == SPC_DIR && wr.addr == $past({8'h00, ins.b1}) &&
		wr.data == $past(rd_data + 8'h01))
		else $error("direct increment wrong");
	data_pointer_step_a: assert property (ins_valid && ins.opcode == 8'ha3 |=>
		data_pointer == $past(data_pointer + 16'h0001))
		else $error("data pointer increment wrong");
	nibble_swap_a: assert property (ins_valid && ins.opcode == 8'hc4 |=>
		acc == $past({acc[3:0], acc[7:4]}))
		else $error("nibble exchange wrong");
	data_pointer_load_a: assert property (ins_valid && ins.opcode == 8'h90 |=>
		data_pointer == $past({ins.b1, ins.b2}))
		else $error("data pointer load wrong");
	cover property (ins_valid && ins.opcode == 8'h12);
	cover property (ins_valid && ins.opcode == 8'he0);
	cover property (wr.we && wr.space == SPC_BIT);
endmodule
bind byte_cpu_instruction_decode byte_cpu_decode_checker chk_i (
	.mclk(mclk), .nrst(nrst), .ins_valid(ins_valid), .ins(ins),
	.rd(rd), .rd_data(rd_data), .wr(wr), .step(step), .done(done),
	.acc(acc), .b(b), .cy(cy), .ac(ac), .ov(ov), .data_pointer(data_pointer), .sp(sp)
);
`default_nettype wire

// [byte_cpu_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module byte_cpu_mem_model (
	// clock
	input wire logic mclk,
	// operand read
	input wire byte_cpu_pkg::mem_req_t rd,
	output var logic [7:0] rd_data
);
	import byte_cpu_pkg::*;
	logic idle_r = 1'b0;
	always_ff @(posedge mclk) begin
		idle_r <= ~idle_r;
	end
	// bytes follow the address unless no space is requested (then 3c/c3 toggling each cycle), bit reads use bit 0
	always_comb begin
		if (rd.space == SPC_NONE) begin
			rd_data = {8{idle_r}} ^ 8'h3c;
		end else begin
			rd_data = rd.addr[7:0] ^ 8'h5a;
		end
	end
endmodule
`default_nettype wire

// [byte_cpu_pkg.sv]
package byte_cpu_pkg;
	typedef enum logic [3:0] {
		SPC_NONE = 4'b0000,
		SPC_WREG = 4'b0001,
		SPC_PTR = 4'b0010,
		SPC_DIR = 4'b0011,
		SPC_BIT = 4'b0100,
		SPC_IRAM = 4'b0101,
		SPC_CODE = 4'b0110,
		SPC_XPTR = 4'b0111,
		SPC_XDATA = 4'b1000
	} space_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [15:0] pc;
	} instr_t;
	typedef struct packed {
		space_t space;
		logic [15:0] addr;
	} mem_req_t;
	typedef struct packed {
		logic we;
		space_t space;
		logic [15:0] addr;
		logic [7:0] data;
	} mem_wr_t;
	typedef struct packed {
		logic [1:0] len;
		logic taken;
		logic [15:0] pc_next;
		logic call;
		logic [15:0] ret_addr;
		logic unknown;
	} step_t;
endpackage

// [tb_byte_cpu_instruction_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_byte_cpu_instruction_decode;
	import byte_cpu_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic ins_valid = 1'b0;
	instr_t ins = '0;
	mem_req_t rd, rd_seen;
	mem_wr_t wr;
	step_t step;
	logic [7:0] rd_data, acc, b, sp;
	logic done, cy, ac, ov;
	logic [15:0] data_pointer;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			n_errors++;
			give_verdict();
		end
	end
	byte_cpu_instruction_decode dut (
		.mclk(mclk), .nrst(nrst), .ins_valid(ins_valid), .ins(ins),
		.rd(rd), .rd_data(rd_data), .wr(wr), .step(step), .done(done),
		.acc(acc), .b(b), .cy(cy), .ac(ac), .ov(ov), .data_pointer(data_pointer), .sp(sp)
	);
	byte_cpu_mem_model mem (.mclk(mclk), .rd(rd), .rd_data(rd_data));
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic note(input logic bad);
		num_checks++;
		if (bad) begin
			n_errors++;
			$display("CHECK FAILED at %0t: value mismatch", $time);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		note(got !== exp);
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		note(got !== exp);
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		note(got !== exp);
	endtask
	task automatic ex(input logic [7:0] op, b1 = 8'h00, b2 = 8'h00,
		input logic [15:0] pc = 16'h0100);
		@(negedge mclk);
		ins = {op, b1, b2, pc};
		ins_valid = 1'b1;
		#1 rd_seen = rd;
		@(negedge mclk);
		ins_valid = 1'b0;
		chk1(done, 1'b1);
	endtask
	task automatic ea(input logic [7:0] op, b1, exp);
		ex(op, b1);
		chk8(acc, exp);
	endtask
	task automatic t_jumps();
		ex(8'h02, 8'h12, 8'h34);
		chk16(step.pc_next, 16'h1234);
		ex(8'h12, 8'hab, 8'hcd, 16'h0020);
		chk16(step.ret_addr, 16'h0023);
		chk1(step.call, 1'b1);
		chk8(sp, 8'h09);
		ex(8'he1, 8'h55, 8'h00, 16'h17fe);
		chk16(step.pc_next, 16'h1f55);
		ex(8'h80, 8'h80);
		chk16(step.pc_next, 16'h0082);
		chk8({6'h0, step.len}, 8'h02);
		chk1(step.taken, 1'b1);
		ex(8'h60, 8'hf0);
		chk1(step.taken, 1'b1);
		chk16(step.pc_next, 16'h00f2);
		ex(8'h70, 8'h10);
		chk1(step.taken, 1'b0);
		chk16(step.pc_next, 16'h0102);
		ex(8'h20, 8'h21, 8'h7f);
		chk16(step.pc_next, 16'h0182);
		ex(8'ha5);
		chk1(step.unknown, 1'b1);
		chk8({6'h0, step.len}, 8'h01);
		ex(8'hd5, 8'h30, 8'h00);
		chk16(step.pc_next, 16'h0103);
		$display("test jumps done");
	endtask
	task automatic t_arith();
		ea(8'h24, 8'ha5, 8'ha5);
		ex(8'hd3);
		ea(8'h34, 8'h01, 8'ha7);
		ea(8'h94, 8'ha8, 8'hff);
		chk1(cy, 1'b1);
		chk1(ac, 1'b1);
		chk1(ov, 1'b0);
		ea(8'h04, 8'h00, 8'h00);
		ea(8'h2b, 8'h00, 8'h59);
		chk16(rd_seen.addr, 16'h0003);
		ex(8'h05, 8'h30);
		chk8(wr.data, 8'h6b);
		chk1(wr.we, 1'b1);
		chk8({4'h0, wr.space}, 8'h03);
		$display("test arith done");
	endtask
	task automatic t_logic();
		ea(8'hf4, 8'h00, 8'ha6);
		ea(8'hc4, 8'h00, 8'h6a);
		ea(8'h23, 8'h00, 8'hd4);
		ea(8'h33, 8'h00, 8'ha8);
		ea(8'h13, 8'h00, 8'hd4);
		chk1(cy, 1'b0);
		ex(8'h63, 8'h40, 8'h0f);
		chk8(wr.data, 8'h15);
		ea(8'he4, 8'h00, 8'h00);
		$display("test logic done");
	endtask
	task automatic t_xfer();
		ex(8'h90, 8'h12, 8'h34);
		ex(8'ha3);
		chk16(data_pointer, 16'h1235);
		ea(8'he0, 8'h00, 8'h6f);
		chk16(rd_seen.addr, 16'h0235);
		ex(8'hf0);
		chk16(wr.addr, 16'h0235);
		chk8(wr.data, 8'h6f);
		chk8({4'h0, wr.space}, 8'h08);
		ex(8'h85, 8'h11, 8'h22);
		chk16(wr.addr, 16'h0022);
		ex(8'hc0, 8'h40);
		chk16(wr.addr, 16'h000a);
		ea(8'hc5, 8'h30, 8'h6a);
		ea(8'he3, 8'h00, 8'h5b);
		chk8({4'h0, rd_seen.space}, 8'h07);
		ea(8'ha4, 8'h00, 8'h00);
		chk8(b, 8'h00);
		chk1(ov, 1'b0);
		ea(8'h84, 8'h00, 8'h00);
		chk1(ov, 1'b1);
		ea(8'h93, 8'h00, 8'h6f);
		$display("test transfer done");
	endtask
	task automatic t_bool();
		ex(8'hd3);
		ex(8'hb0, 8'h21);
		chk1(cy, 1'b0);
		ex(8'ha2, 8'h21);
		chk1(cy, 1'b1);
		ex(8'hc2, 8'h45);
		chk16(wr.addr, 16'h0045);
		chk8({4'h0, wr.space}, 8'h04);
		chk8(wr.data, 8'h00);
		$display("test boolean done");
	endtask
	task automatic t_decimal();
		ea(8'h74, 8'h59, 8'h59);
		ex(8'hc3);
		chk1(cy, 1'b0);
		ea(8'h24, 8'h28, 8'h81);
		chk1(ac, 1'b1);
		ea(8'hd4, 8'h00, 8'h87);
		chk1(cy, 1'b0);
		ea(8'h24, 8'h20, 8'ha7);
		ea(8'hd4, 8'h00, 8'h07);
		chk1(cy, 1'b1);
		$display("test decimal done");
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		nrst = 1'b1;
		chk8(sp, 8'h07);
		t_jumps();
		t_arith();
		t_logic();
		t_xfer();
		t_bool();
		t_decimal();
		give_verdict();
	end
endmodule
`default_nettype wire
